/* dbi_consts.svh */
// Timing counts and field positions for the DDR2 burst access model.
// Assumes inclusion by dbi_pkg.sv and dbi_top.sv by bare name.
`ifndef DBI_CONSTS_SVH
`define DBI_CONSTS_SVH
// ****************************************
// Geometry
// ****************************************
`define DBI_BANKS 8
`define DBI_ROW_W 13
`define DBI_COL_W 10
`define DBI_BYTE_W 8
`define DBI_DQ_W 16
`define DBI_PREFETCH 4
`define DBI_A10 10
`define DBI_FIFO_DEPTH 4
// ****************************************
// Timing
// ****************************************
`define DBI_CLK_NS 5
`define DBI_TRP_NS 15
`define DBI_TRP_CYC ((`DBI_TRP_NS + `DBI_CLK_NS - 1) / `DBI_CLK_NS)
`define DBI_BL4 4
`define DBI_BL8 8
`endif

/* dbi_pkg.sv */
// Types for the DDR2 burst access model.
// Assumes dbi_consts.svh is on the include path.
`include "dbi_consts.svh"
package dbi_pkg;
    typedef enum logic [2:0] {
        DBI_CMD_NOP, DBI_CMD_ACT, DBI_CMD_RD, DBI_CMD_WR,
        DBI_CMD_PRE, DBI_CMD_REF, DBI_CMD_LMR
    } dbi_cmd_t;
    typedef enum logic [1:0] {DBI_BK_IDLE, DBI_BK_OPEN, DBI_BK_PRE} dbi_bank_st_t;
    typedef enum logic [1:0] {DBI_PW_ON, DBI_PW_PD_PRE, DBI_PW_PD_ACT, DBI_PW_SELF} dbi_pw_t;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [2:0] ba;
        logic [12:0] addr;
    } dbi_cmd_pins_t;
    typedef struct packed {
        logic [15:0] dq;
        logic [1:0] dm;
    } dbi_beat_t;
    typedef struct packed {
        logic [2:0] bank;
        logic [12:0] row;
        logic [9:0] col;
        logic [1:0] beat;
        logic we;
        logic [63:0] data;
        logic [7:0] mask;
    } dbi_word_t;
endpackage

/* dbi_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module dbi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dbi_fifo_st_t;
    dbi_fifo_st_t s_q, s_d;
    logic push, pop;
    assign in_ready = (s_q.cnt != DEPTH[AW:0]);
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : AW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : AW'(s_q.rp + 1'b1);
        end
        s_d.cnt = AW'(0) + s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* dbi_top.sv */
// DDR2 device-side burst access model: command decode, bank state,
// burst engine, strobe sampling and a small flip-flop array.
// Assumes all link pins (ck, dqs, command) arrive asynchronous to clock,
// which oversamples them; ck runs far slower than clock.
//
// Function
// RQ1: Four half-clock beats form one prefetch word
// RQ2: Device drives strobe only during read bursts
// RQ3: Read strobe edges coincide with data edges
// RQ4: Each byte has own strobe and mask; code takes both bytes on either strobe edge and drives both strobes alike
// RQ5: Commands captured on each rising link clock
// RQ6: Write data captured on both strobe edges
// RQ7: Controller starts access with activate first
// RQ8: Activate picks bank and row
// RQ9: Read/write picks bank and start column
// RQ10: Burst runs 4 or 8, programmed order
// RQ11: New read/write cuts a burst short
// RQ12: Auto precharge closes row after burst
// RQ13: Banks precharge while others take commands
// RQ14: Self refresh and power-down modes exist
// RQ15: Controller doubles refresh above hot threshold
// RQ16: Behaviour defined only with DLL enabled
// RQ17: A10 selects one bank or all banks
// RQ18: Chip select high masks every command
// RQ19: Bank bits pick mode register on load
// RQ20: CKE low enters power-down or self refresh
// RQ21: Controller uses reads/writes only on open rows
`timescale 1ns/1ps
`include "dbi_consts.svh"
module dbi_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link clock and command pins
    input wire logic ck,
    input wire dbi_pkg::dbi_cmd_pins_t cmd_pins,
    // Data pins, two-way: output enable low while driving
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic [1:0] dm_in,
    input wire logic [1:0] dqs_in,
    output logic [1:0] dqs_out,
    output logic [1:0] dqs_oe_n,
    // Status
    output dbi_pkg::dbi_pw_t power_state,
    output logic [`DBI_BANKS-1:0] bank_open
);
    localparam int NB = `DBI_BANKS;
    localparam int MEM_W = 64;
    localparam logic [3:0] TRP = 4'(`DBI_TRP_CYC);

    // ****************************************
    // Synchronisers
    // ****************************************
    typedef struct packed {
        logic [1:0] ck_s;
        logic [1:0][1:0] dqs_s;
        logic [1:0][$bits(dbi_pkg::dbi_cmd_pins_t)-1:0] cmd_s;
        logic [1:0][17:0] dat_s;
        logic ck_last;
        logic [1:0] dqs_last;
    } dbi_sync_t;
    dbi_sync_t y_q, y_d;
    always_comb begin
        y_d = y_q;
        y_d.ck_s = {y_q.ck_s[0], ck};
        y_d.dqs_s = {y_q.dqs_s[0], dqs_in};
        y_d.cmd_s = {y_q.cmd_s[0], cmd_pins};
        y_d.dat_s = {y_q.dat_s[0], {dm_in, dq_in}};
        y_d.ck_last = y_q.ck_s[1];
        y_d.dqs_last = y_q.dqs_s[1];
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            y_q <= '0;
        end else begin
            y_q <= y_d;
        end
    end
    dbi_pkg::dbi_cmd_pins_t cp;
    logic ck_rise, ck_edge;
    logic [1:0] dqs_edge;
    assign cp = y_q.cmd_s[1];
    assign ck_rise = y_q.ck_s[1] && !y_q.ck_last; // see RQ5
    assign ck_edge = y_q.ck_s[1] ^ y_q.ck_last;
    assign dqs_edge = y_q.dqs_s[1] ^ y_q.dqs_last; // see RQ6

    // ****************************************
    // Command decode
    // ****************************************
    dbi_pkg::dbi_cmd_t cmd;
    always_comb begin
        cmd = dbi_pkg::DBI_CMD_NOP;
        if (!cp.cs_n) begin // see RQ18
            unique case ({cp.ras_n, cp.cas_n, cp.we_n})
                3'h3: cmd = dbi_pkg::DBI_CMD_ACT;
                3'h5: cmd = dbi_pkg::DBI_CMD_RD;
                3'h4: cmd = dbi_pkg::DBI_CMD_WR;
                3'h2: cmd = dbi_pkg::DBI_CMD_PRE;
                3'h1: cmd = dbi_pkg::DBI_CMD_REF;
                3'h0: cmd = dbi_pkg::DBI_CMD_LMR;
                default: cmd = dbi_pkg::DBI_CMD_NOP;
            endcase
        end
    end

    // ****************************************
    // Prefetch word FIFO toward the array
    // ****************************************
    dbi_pkg::dbi_word_t f_in, f_out;
    logic f_in_valid, f_in_ready, f_out_valid;
    dbi_fifo #(.WIDTH($bits(dbi_pkg::dbi_word_t)), .DEPTH(`DBI_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in),
        .out_valid(f_out_valid),
        .out_ready(1'b1),
        .out_data(f_out)
    );

    // ****************************************
    // Core state
    // ****************************************
    typedef struct packed {
        logic [NB-1:0][1:0] bst;
        logic [NB-1:0][12:0] row;
        logic [NB-1:0][3:0] pre_cnt;
        logic [3:0][12:0] mode;
        dbi_pkg::dbi_pw_t pw;
        logic rd;
        logic wr;
        logic ap;
        logic [2:0] bank;
        logic [9:0] col;
        logic [3:0] beat;
        logic [3:0] len;
        logic [63:0] acc;
        logic [7:0] macc;
        logic [15:0] dq_o;
        logic [1:0] dqs_o;
        logic drive;
        logic [7:0][63:0] mem;
    } dbi_core_t;
    dbi_core_t c_q, c_d;

    logic [3:0] bl;
    logic interleave;
    logic any_open;
    logic [2:0] beat_col;
    logic [1:0] lane;
    assign bl = c_q.mode[0][2:0] == 3'h3 ? 4'(`DBI_BL8) : 4'(`DBI_BL4);
    assign interleave = c_q.mode[0][3];
    always_comb begin
        any_open = 1'b0;
        for (int i = 0; i < NB; i++) begin
            any_open = any_open | (c_q.bst[i] == 2'(dbi_pkg::DBI_BK_OPEN));
        end
    end
    // Column of the current beat, wrapping inside the burst window
    always_comb begin
        beat_col = interleave ? (c_q.col[2:0] ^ c_q.beat[2:0]) : 3'(c_q.col[2:0] + c_q.beat[2:0]); // see RQ10
        if (bl == 4'(`DBI_BL4)) begin
            beat_col = {c_q.col[2], beat_col[1:0]};
        end
    end
    assign lane = beat_col[1:0];
    // Array storage is a small window: row bits are not kept, trading depth for area
    logic [2:0] widx;
    assign widx = {c_q.bank[0], c_q.col[3], beat_col[2]};

    always_comb begin
        c_d = c_q;
        f_in_valid = 1'b0;
        f_in = '0;
        // Self-timed precharge runs per bank, independent of the command stream
        for (int i = 0; i < NB; i++) begin
            if (c_q.bst[i] == 2'(dbi_pkg::DBI_BK_PRE)) begin // see RQ13
                c_d.pre_cnt[i] = c_q.pre_cnt[i] - 4'h1;
                if (c_q.pre_cnt[i] == 4'h1) begin
                    c_d.bst[i] = 2'(dbi_pkg::DBI_BK_IDLE);
                end
            end
        end
        // Read beats go out on every link clock edge, strobe follows data
        if (c_q.rd && ck_edge) begin // see RQ16
            if (c_q.beat == c_q.len) begin
                // Last beat must stand a full half period before the pins are let go
                c_d.rd = 1'b0;
                c_d.drive = 1'b0;
            end else begin
                c_d.dq_o = c_q.mem[widx][16*lane +: 16]; // see RQ1
                c_d.dqs_o = {2{~c_q.beat[0]}}; // see RQ3
                c_d.beat = c_q.beat + 4'h1;
            end
        end
        // Write beats are taken on any strobe edge, both byte lanes at once
        if (c_q.wr && (dqs_edge != 2'h0)) begin
            for (int b = 0; b < 2; b++) begin // see RQ4
                c_d.acc[16*lane + 8*b +: 8] = y_q.dat_s[1][8*b +: 8];
                c_d.macc[2*lane + b] = y_q.dat_s[1][16+b];
            end
            c_d.beat = c_q.beat + 4'h1;
            if (lane == 2'h3 || c_q.beat == c_q.len - 4'h1) begin
                f_in_valid = 1'b1;
                f_in.bank = c_q.bank;
                f_in.col = {c_q.col[9:3], beat_col};
                f_in.beat = 2'(c_q.beat >> 2);
                f_in.we = 1'b1;
                f_in.data = c_d.acc;
                f_in.mask = c_d.macc;
                c_d.macc = '0;
            end
            if (c_q.beat == c_q.len - 4'h1) begin
                c_d.wr = 1'b0;
            end
        end
        // Auto precharge at burst end
        if ((c_q.rd && !c_d.rd) || (c_q.wr && !c_d.wr)) begin
            if (c_q.ap) begin // see RQ12
                c_d.bst[c_q.bank] = 2'(dbi_pkg::DBI_BK_PRE);
                c_d.pre_cnt[c_q.bank] = TRP;
            end
        end
        // Retire buffered words into the array, honouring per-byte masks
        if (f_out_valid) begin
            for (int k = 0; k < 8; k++) begin
                if (!f_out.mask[k]) begin
                    c_d.mem[{f_out.bank[0], f_out.col[3], f_out.col[2]}][8*k +: 8] = f_out.data[8*k +: 8];
                end
            end
        end
        // Commands, one per rising link clock
        if (ck_rise) begin
            if (!cp.cke && c_q.pw == dbi_pkg::DBI_PW_ON && !c_q.rd && !c_q.wr) begin
                if (any_open) begin // see RQ20
                    c_d.pw = dbi_pkg::DBI_PW_PD_ACT;
                end else if (cmd == dbi_pkg::DBI_CMD_REF) begin
                    c_d.pw = dbi_pkg::DBI_PW_SELF; // see RQ14
                end else begin
                    c_d.pw = dbi_pkg::DBI_PW_PD_PRE;
                end
            end else if (cp.cke && c_q.pw != dbi_pkg::DBI_PW_ON) begin
                c_d.pw = dbi_pkg::DBI_PW_ON;
            end else if (c_q.pw == dbi_pkg::DBI_PW_ON) begin
                unique case (cmd)
                    dbi_pkg::DBI_CMD_ACT: begin
                        if (c_q.bst[cp.ba] == 2'(dbi_pkg::DBI_BK_IDLE)) begin // see RQ8
                            c_d.bst[cp.ba] = 2'(dbi_pkg::DBI_BK_OPEN);
                            c_d.row[cp.ba] = cp.addr;
                        end
                    end
                    dbi_pkg::DBI_CMD_RD, dbi_pkg::DBI_CMD_WR: begin
                        // A new access cuts any burst in flight short
                        if (c_q.bst[cp.ba] == 2'(dbi_pkg::DBI_BK_OPEN)) begin // see RQ11
                            c_d.rd = (cmd == dbi_pkg::DBI_CMD_RD);
                            c_d.wr = (cmd == dbi_pkg::DBI_CMD_WR);
                            c_d.drive = (cmd == dbi_pkg::DBI_CMD_RD); // see RQ2
                            c_d.bank = cp.ba; // see RQ9
                            c_d.col = cp.addr[9:0];
                            c_d.ap = cp.addr[`DBI_A10];
                            c_d.beat = 4'h0;
                            c_d.len = bl;
                            c_d.acc = '0;
                            c_d.macc = '0;
                        end
                    end
                    dbi_pkg::DBI_CMD_PRE: begin
                        for (int i = 0; i < NB; i++) begin
                            if ((cp.addr[`DBI_A10] || cp.ba == 3'(i)) && // see RQ17
                                c_q.bst[i] == 2'(dbi_pkg::DBI_BK_OPEN)) begin
                                c_d.bst[i] = 2'(dbi_pkg::DBI_BK_PRE);
                                c_d.pre_cnt[i] = TRP;
                            end
                        end
                    end
                    dbi_pkg::DBI_CMD_LMR: begin
                        c_d.mode[cp.ba[1:0]] = cp.addr; // see RQ19
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign dq_out = c_q.dq_o;
    assign dq_oe_n = ~c_q.drive;
    assign dqs_out = c_q.dqs_o;
    assign dqs_oe_n = {2{~c_q.drive}}; // see RQ2
    assign power_state = c_q.pw;
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            bank_open[i] = (c_q.bst[i] == 2'(dbi_pkg::DBI_BK_OPEN));
        end
    end
endmodule

/* dbi_checker.sv */
// Port assertions for the DDR2 burst access block.
// Assumes binding into dbi_top; ck runs far slower than clock.
`timescale 1ns/1ps
`include "dbi_consts.svh"
module dbi_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link pins
    input wire logic ck,
    input wire dbi_pkg::dbi_cmd_pins_t cmd_pins,
    input wire logic [15:0] dq_in,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic [1:0] dm_in,
    input wire logic [1:0] dqs_in,
    input wire logic [1:0] dqs_out,
    input wire logic [1:0] dqs_oe_n,
    // Status
    input wire dbi_pkg::dbi_pw_t power_state,
    input wire logic [`DBI_BANKS-1:0] bank_open
);
    logic [2:0] op;
    logic [`DBI_BANKS-1:0] prev_q;
    assign op = {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= bank_open;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ****
    // Command steps
    // ****
    sequence live_s;
        $rose(ck) && !cmd_pins.cs_n && cmd_pins.cke && power_state == dbi_pkg::DBI_PW_ON;
    endsequence
    sequence act_s;
        live_s ##0 (op == 3'h3 && !bank_open[cmd_pins.ba]);
    endsequence
    sequence rd_s;
        live_s ##0 (op == 3'h5 && bank_open[cmd_pins.ba]);
    endsequence
    sequence pre_all_s;
        live_s ##0 (op == 3'h2 && cmd_pins.addr[10]);
    endsequence
    // Only a plain no-op or a deselect may carry the power-down entry
    sequence low_s;
        $rose(ck) && !cmd_pins.cke && power_state == dbi_pkg::DBI_PW_ON;
    endsequence
    // ****
    // Assertions
    // ****
    act_opens_row_a: assert property (act_s |-> ##[1:6] bank_open[cmd_pins.ba])
        else $error("activate did not open the row");
    rd_drives_a: assert property (rd_s |-> ##[1:8] !dq_oe_n)
        else $error("read did not drive data");
    pre_all_a: assert property (pre_all_s |-> ##[2:14] bank_open == 8'h00)
        else $error("precharge all left a row open");
    cs_mask_a: assert property ($rose(ck) && cmd_pins.cs_n |-> ##1 ((bank_open & ~prev_q) == 8'h00) [*8])
        else $error("deselected command opened a row");
    pd_active_a: assert property (low_s ##0 (cmd_pins.cs_n || op == 3'h7) && (|bank_open)
        |-> ##[1:8] power_state == dbi_pkg::DBI_PW_PD_ACT)
        else $error("no active power-down");
    pd_precharge_a: assert property (low_s ##0 (cmd_pins.cs_n || op == 3'h7) && bank_open == 8'h00
        |-> ##[1:8] power_state == dbi_pkg::DBI_PW_PD_PRE)
        else $error("no precharge power-down");
    self_ref_a: assert property (low_s ##0 !cmd_pins.cs_n && op == 3'h1 && bank_open == 8'h00
        |-> ##[1:8] power_state == dbi_pkg::DBI_PW_SELF)
        else $error("no self refresh");
    strobe_enable_a: assert property (dqs_oe_n == {2{dq_oe_n}})
        else $error("strobe enable differs from data enable");
    strobe_pair_a: assert property (!dq_oe_n |-> dqs_out[0] == dqs_out[1])
        else $error("byte strobes disagree");
    edge_align_a: assert property (!dq_oe_n && !$past(dq_oe_n) && $changed(dq_out) |-> $changed(dqs_out))
        else $error("read data moved without a strobe edge");
endmodule
bind dbi_top dbi_checker chk_u (.clock(clock), .rst_n(rst_n), .ck(ck), .cmd_pins(cmd_pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dm_in(dm_in), .dqs_in(dqs_in), .dqs_out(dqs_out),
    .dqs_oe_n(dqs_oe_n), .power_state(power_state), .bank_open(bank_open));

/* dbi_ctrl_model.sv */
// Controller-side model: free link clock, commands and write bursts.
// Assumes the bench calls one task at a time, timed off clock.
`timescale 1ns/1ps
module dbi_ctrl_model (
    // Timing reference
    input wire logic clock,
    // Pins towards the device
    output logic ck,
    output dbi_pkg::dbi_cmd_pins_t cmd_pins,
    output logic [15:0] dq,
    output logic [1:0] dm,
    output logic [1:0] dqs
);
    initial begin
        ck = 1'b0;
        cmd_pins = {1'b1, 3'h7, 1'b1, 16'h0000};
        dq = 16'h0000;
        dm = 2'h0;
        dqs = 2'h0;
    end
    // Offset so link edges never land on a clock edge
    initial begin
        #1.3;
        forever #80 ck = ~ck;
    end
    // Pins change while ck is low and hold across its rising edge
    task automatic cmd(input logic cs_n, input logic [2:0] op, input logic cke, input logic [2:0] ba,
        input logic [12:0] addr);
        @(negedge ck);
        @(posedge clock);
        #1;
        cmd_pins = {cs_n, op, cke, ba, addr};
        @(negedge ck);
        @(posedge clock);
        #1;
        cmd_pins = {1'b1, 3'h7, cke, ~ba, ~addr};
    endtask
    // Strobe edge sits mid-bit; strobe rests low as if terminated
    task automatic wr_beats(input logic [63:0] data, input logic [7:0] mask);
        for (int i = 0; i < 4; i++) begin
            dq = data[16*i +: 16];
            dm = mask[2*i +: 2];
            repeat (8) @(posedge clock);
            #1;
            dqs = ~dqs;
            repeat (8) @(posedge clock);
            #1;
        end
        dq = ~dq;
    endtask
endmodule

/* tb_top.sv */
// Testbench: controller model drives the link, bench judges the replies.
// Assumes the design, checker and controller model compile first.
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ck, dq_oe_n;
    dbi_pkg::dbi_cmd_pins_t cmd_pins;
    dbi_pkg::dbi_pw_t power_state;
    logic [15:0] ctl_dq, dq_out, dq_wire;
    logic [1:0] ctl_dm, ctl_dqs, dqs_out, dqs_oe_n, dqs_wire;
    logic [7:0] bank_open;
    logic [63:0] w, got;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Device drive wins the shared wires only while enabled
    assign dq_wire = dq_oe_n ? ctl_dq : dq_out;
    assign dqs_wire[0] = dqs_oe_n[0] ? ctl_dqs[0] : dqs_out[0];
    assign dqs_wire[1] = dqs_oe_n[1] ? ctl_dqs[1] : dqs_out[1];
    always #2.5 clock = ~clock;
    dbi_ctrl_model ctl_u (.clock(clock), .ck(ck), .cmd_pins(cmd_pins), .dq(ctl_dq), .dm(ctl_dm), .dqs(ctl_dqs));
    dbi_top dut_u (.clock(clock), .rst_n(rst_n), .ck(ck), .cmd_pins(cmd_pins), .dq_in(dq_wire),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dm_in(ctl_dm), .dqs_in(dqs_wire), .dqs_out(dqs_out),
        .dqs_oe_n(dqs_oe_n), .power_state(power_state), .bank_open(bank_open));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs about 2000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // Read from bank 2, one beat collected at each of the first four strobe edges
    task automatic rd(input logic [9:0] col, input logic ap);
        int n;
        logic last;
        n = 0;
        last = 1'b0;
        got = 64'h0;
        fork
            ctl_u.cmd(1'b0, 3'h5, 1'b1, 3'h2, {2'b00, ap, col});
            for (int i = 0; i < 400 && n < 4; i++) begin
                @(posedge clock);
                #1;
                if (dq_oe_n === 1'b0 && dqs_out[0] !== last) begin
                    got[16*n +: 16] = dq_out;
                    n++;
                end
                last = dqs_out[0];
            end
        join
        check(n, 4);
    endtask
    task automatic t_reset;
        check({dq_out, dqs_out, dqs_oe_n, dq_oe_n, power_state, bank_open},
            {16'h0000, 2'h0, 2'h3, 1'b1, 2'h0, 8'h00});
    endtask
    task automatic t_rows;
        ctl_u.cmd(1'b1, 3'h3, 1'b1, 3'h3, 13'h0005);
        check(bank_open, 8'h00);
        ctl_u.cmd(1'b0, 3'h0, 1'b1, 3'h0, 13'h0002);
        ctl_u.cmd(1'b0, 3'h3, 1'b1, 3'h2, 13'h0005);
        check(bank_open, 8'h04);
    endtask
    // Sequential then interleaved order from column 1, masked upper byte
    task automatic t_data;
        w = 64'h4444_3333_2222_1111;
        ctl_u.cmd(1'b0, 3'h4, 1'b1, 3'h2, 13'h0000);
        ctl_u.wr_beats(w, 8'h00);
        rd(10'h001, 1'b0);
        check(got, {w[15:0], w[63:16]});
        ctl_u.cmd(1'b0, 3'h4, 1'b1, 3'h2, 13'h0000);
        ctl_u.wr_beats(64'hdddd_cccc_bbbb_aaaa, 8'haa);
        w = (w & 64'hff00_ff00_ff00_ff00) | 64'h00dd_00cc_00bb_00aa;
        rd(10'h001, 1'b1);
        check(got, {w[15:0], w[63:16]});
        repeat (40) @(posedge clock);
        #1;
        check(bank_open, 8'h00);
        ctl_u.cmd(1'b0, 3'h0, 1'b1, 3'h0, 13'h000a);
        ctl_u.cmd(1'b0, 3'h3, 1'b1, 3'h2, 13'h0005);
        rd(10'h001, 1'b0);
        check(got, {w[47:32], w[63:48], w[15:0], w[31:16]});
    endtask
    // Eight-beat sequential burst wrapping from column 6
    task automatic t_bl8;
        ctl_u.cmd(1'b0, 3'h0, 1'b1, 3'h0, 13'h0003);
        rd(10'h006, 1'b0);
        check(got, {w[31:16], w[15:0], 32'h0});
        repeat (100) @(posedge clock);
        #1;
    endtask
    task automatic t_multi;
        ctl_u.cmd(1'b0, 3'h3, 1'b1, 3'h5, 13'h0009);
        check(bank_open, 8'h24);
        ctl_u.cmd(1'b0, 3'h2, 1'b1, 3'h0, 13'h0400);
        check(bank_open, 8'h00);
    endtask
    // Enter with cke low, then leave with cke high
    task automatic pw(input logic [2:0] op, input dbi_pkg::dbi_pw_t exp);
        ctl_u.cmd(1'b0, op, 1'b0, 3'h0, 13'h0000);
        check(power_state, exp);
        ctl_u.cmd(1'b0, 3'h7, 1'b1, 3'h0, 13'h0000);
        repeat (20) @(posedge clock);
        #1;
        check(power_state, dbi_pkg::DBI_PW_ON);
    endtask
    task automatic t_power;
        ctl_u.cmd(1'b0, 3'h3, 1'b1, 3'h1, 13'h0003);
        pw(3'h7, dbi_pkg::DBI_PW_PD_ACT);
        ctl_u.cmd(1'b0, 3'h2, 1'b1, 3'h0, 13'h0400);
        pw(3'h7, dbi_pkg::DBI_PW_PD_PRE);
        pw(3'h1, dbi_pkg::DBI_PW_SELF);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_rows();
        t_data();
        t_bl8();
        t_multi();
        t_power();
        complete_run();
    end
endmodule
